// ---- inc/soft_reset_bank_two_pkg.sv ----
// constants, types and field layout of the second soft reset control bank
// What this block does
// [RQ1] writes gated by capability mask four bits
// [RQ2] register at 0x048, read/write, resets zero
// [RQ3] bit 30 resets the Ethernet PHY
// [RQ4] bit 28 resets the Ethernet MAC
// [RQ5] bits 7..0 reset I/O ports H..A
// [RQ6] bits 31, 29, 27:8 read zero
// [RQ7] set bit holds unit in reset
`default_nettype none

package soft_reset_bank_two_pkg;

	// ==========================================================
	// bus geometry
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int OFFS_W = 12;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// ==========================================================
	// register map
	localparam logic [OFFS_W-1:0] SOFT_RESET_CONTROL_GROUP_TWO_OFFSET = 12'h048;
	localparam logic [OFFS_W-1:0] CAPABILITY_MASK_FOUR_OFFSET = 12'h01C;
	localparam logic [DATA_W-1:0] SOFT_RESET_CONTROL_GROUP_TWO_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CAPABILITY_MASK_FOUR_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

	// ==========================================================
	// field layout
	localparam int PHY_BIT = 30;
	localparam int MAC_BIT = 28;
	localparam int PORT_LSB = 0;
	localparam int PORT_COUNT = 8;
	localparam logic [DATA_W-1:0] WRITABLE_MASK = 32'h5000_00FF;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic valid;
		logic write;
		logic [OFFS_W-1:0] offset;
		logic wordSize;
	} busPhase_t;

	typedef struct packed {
		logic phy;
		logic mac;
		logic [PORT_COUNT-1:0] ports;
	} resetLines_t;

	localparam busPhase_t BUS_PHASE_IDLE = '{valid: 1'b0, write: 1'b0, offset: 12'h000,
		wordSize: 1'b0};

endpackage

`default_nettype wire

// ---- logic/soft_reset_bank_two.sv ----
// AHB-Lite slave holding the second soft reset control bank and its reset outputs
`default_nettype none

module soft_reset_bank_two
	import soft_reset_bank_two_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [DATA_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [DATA_W-1:0] hrdata,
	input wire logic [DATA_W-1:0] capabilityMaskFour,
	output logic ethernetPhyReset,
	output logic ethernetMacReset,
	output logic ioPortHReset,
	output logic ioPortGReset,
	output logic ioPortFReset,
	output logic ioPortEReset,
	output logic ioPortDReset,
	output logic ioPortCReset,
	output logic ioPortBReset,
	output logic ioPortAReset
);

	// ==========================================================
	// reset release
	logic rstMeta_n;
	logic rstSync_n;

	// assert is immediate, release waits two edges so no flop sees a runt release
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_n <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_n <= 1'b1;
			rstSync_n <= rstMeta_n;
		end
	end

	// ==========================================================
	// decode helpers
	function automatic logic isControlReg(input logic [OFFS_W-1:0] offs);
		return offs == SOFT_RESET_CONTROL_GROUP_TWO_OFFSET;
	endfunction

	function automatic logic isCapabilityReg(input logic [OFFS_W-1:0] offs);
		return offs == CAPABILITY_MASK_FOUR_OFFSET;
	endfunction

	// ==========================================================
	// capability mask
	// registered once so reads and write gating see the same copy
	logic [DATA_W-1:0] capMask;
	logic [DATA_W-1:0] next_capMask;

	always_comb begin
		next_capMask = capabilityMaskFour;
	end

	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			capMask <= CAPABILITY_MASK_FOUR_RESET;
		end else begin
			capMask <= next_capMask;
		end
	end

	// ==========================================================
	// address phase capture
	busPhase_t dataPhase;
	busPhase_t next_dataPhase;
	logic addrAccepted;

	assign addrAccepted = hsel && hready && (htrans == HTRANS_NONSEQ);

	always_comb begin
		next_dataPhase = dataPhase;
		if (hready) begin
			if (addrAccepted) begin
				next_dataPhase.valid = 1'b1;
				next_dataPhase.write = hwrite;
				next_dataPhase.offset = haddr[OFFS_W-1:0];
				next_dataPhase.wordSize = (hsize == HSIZE_WORD) && (haddr[1:0] == WORD_ALIGN);
			end else begin
				next_dataPhase = BUS_PHASE_IDLE;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			dataPhase <= BUS_PHASE_IDLE;
		end else begin
			dataPhase <= next_dataPhase;
		end
	end

	// ==========================================================
	// control register
	logic [DATA_W-1:0] ctrl;
	logic [DATA_W-1:0] next_ctrl;
	logic ctrlWrite;

	// narrow or misaligned writes are dropped rather than merged
	assign ctrlWrite = dataPhase.valid && dataPhase.write && dataPhase.wordSize
		&& isControlReg(dataPhase.offset);

	always_comb begin
		next_ctrl = ctrl;
		if (ctrlWrite) begin
			next_ctrl = hwdata & capMask & WRITABLE_MASK; // [RQ1] [RQ6]
		end
	end

	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			ctrl <= SOFT_RESET_CONTROL_GROUP_TWO_RESET; // [RQ2]
		end else begin
			ctrl <= next_ctrl; // [RQ7]
		end
	end

	// ==========================================================
	// read path
	// read data is prepared at the address phase from next_ctrl so a read
	// right behind a write already sees the new value with no wait state
	logic [DATA_W-1:0] readData;
	logic [DATA_W-1:0] next_readData;

	always_comb begin
		next_readData = readData;
		if (addrAccepted && !hwrite) begin
			if (isControlReg(haddr[OFFS_W-1:0])) begin
				next_readData = next_ctrl & WRITABLE_MASK; // [RQ2] [RQ6]
			end else if (isCapabilityReg(haddr[OFFS_W-1:0])) begin
				next_readData = capMask;
			end else begin
				next_readData = READ_ZERO;
			end
		end else if (hready) begin
			next_readData = READ_ZERO;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			readData <= READ_ZERO;
		end else begin
			readData <= next_readData;
		end
	end

	assign hrdata = readData;
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;

	// ==========================================================
	// reset outputs
	resetLines_t lines;
	logic [PORT_COUNT-1:0] portReset;

	genvar gi;
	generate
		for (gi = 0; gi < PORT_COUNT; gi++) begin : g_port
			assign portReset[gi] = ctrl[PORT_LSB + gi]; // [RQ5]
			// one check pair per port line
			a_port_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ5]
				ctrlWrite |=> portReset[gi]
					== ($past(hwdata[PORT_LSB + gi]) && $past(capMask[PORT_LSB + gi])))
				else $error("port reset line does not follow its write");
			a_port_held: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ7]
				(portReset[gi] && !ctrlWrite) |=> portReset[gi])
				else $error("port reset released without a write");
		end
	endgenerate

	assign lines.phy = ctrl[PHY_BIT]; // [RQ3]
	assign lines.mac = ctrl[MAC_BIT]; // [RQ4]
	assign lines.ports = portReset;

	// outputs are straight flip-flop bits: held while set, released on clear
	assign ethernetPhyReset = lines.phy; // [RQ7]
	assign ethernetMacReset = lines.mac;
	assign ioPortHReset = lines.ports[7];
	assign ioPortGReset = lines.ports[6];
	assign ioPortFReset = lines.ports[5];
	assign ioPortEReset = lines.ports[4];
	assign ioPortDReset = lines.ports[3];
	assign ioPortCReset = lines.ports[2];
	assign ioPortBReset = lines.ports[1];
	assign ioPortAReset = lines.ports[0];

	// ==========================================================
	// checks
	a_write_gated: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ1]
		ctrlWrite |=> ctrl == ($past(hwdata) & $past(capMask) & WRITABLE_MASK))
		else $error("control write not gated by capability mask");

	a_reset_clears: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ2]
		!rstSync_n |-> (ctrl == SOFT_RESET_CONTROL_GROUP_TWO_RESET && !ethernetPhyReset
			&& !ethernetMacReset && !ioPortAReset && !ioPortHReset))
		else $error("control register not cleared during reset");

	a_read_back: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ2]
		(addrAccepted && !hwrite && isControlReg(haddr[OFFS_W-1:0]) && !ctrlWrite)
			##1 !ctrlWrite |-> hrdata == ctrl)
		else $error("control register read mismatch");

	a_phy_line: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ3]
		ctrlWrite |=> ethernetPhyReset == ($past(hwdata[PHY_BIT]) && $past(capMask[PHY_BIT])))
		else $error("phy reset line does not follow bit 30");

	a_mac_line: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ4]
		ctrlWrite |=> ethernetMacReset == ($past(hwdata[MAC_BIT]) && $past(capMask[MAC_BIT])))
		else $error("mac reset line does not follow bit 28");

	a_port_lines: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ5]
		{ioPortHReset, ioPortGReset, ioPortFReset, ioPortEReset, ioPortDReset,
			ioPortCReset, ioPortBReset, ioPortAReset} == ctrl[PORT_LSB +: PORT_COUNT])
		else $error("port reset lines out of order");

	a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ6]
		dataPhase.valid && !dataPhase.write |-> (hrdata & ~WRITABLE_MASK) == READ_ZERO
			|| isCapabilityReg(dataPhase.offset))
		else $error("reserved bits read nonzero");

	a_reset_held: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ7]
		(ethernetPhyReset && !ctrlWrite) |=> ethernetPhyReset)
		else $error("phy reset released without a write");

	a_release_on_clear: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ7]
		(ctrlWrite && !hwdata[MAC_BIT]) |=> !ethernetMacReset)
		else $error("mac reset not released on clear");

	a_bus_okay: assert property (@(posedge mclk) disable iff (!rstSync_n)
		(addrAccepted && !hwrite && !isControlReg(haddr[OFFS_W-1:0])
			&& !isCapabilityReg(haddr[OFFS_W-1:0]))
			|=> (hrdata == READ_ZERO && hreadyout && hresp == HRESP_OKAY))
		else $error("unmapped read not answered with zero");

	// ==========================================================
	// bus, capability mask and synchroniser checks
	a_rsp_okay: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ2]
		hreadyout && hresp == HRESP_OKAY)
		else $error("slave stalled or answered with an error");

	// stale read data must not linger on the bus after its data phase
	a_idle_read_zero: assert property (@(posedge mclk) disable iff (!rstSync_n)
		(hready && !(addrAccepted && !hwrite)) |=> hrdata == READ_ZERO)
		else $error("read data left standing outside a read");

	a_cap_read: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ1]
		(addrAccepted && !hwrite && isCapabilityReg(haddr[OFFS_W-1:0]))
			|=> hrdata == $past(capMask))
		else $error("capability mask read mismatch");

	// live mask: a bit dropped later leaves an already set control bit alone
	a_cap_sampled: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ1]
		1'b1 |=> capMask == $past(capabilityMaskFour))
		else $error("capability mask copy lags its input");

	// watched on the raw pin so the release edges themselves are covered
	a_sync_two_stage: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ2]
		!rstMeta_n |=> !rstSync_n)
		else $error("reset released through fewer than two stages");

	// ==========================================================
	// register and reset line checks
	// apart from reset, reset outputs only ever move on a write data phase
	a_ctrl_stable: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ7]
		!ctrlWrite |=> $stable(ctrl))
		else $error("control register changed without a write");

	a_reserved_ctrl: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ6]
		(ctrl & ~WRITABLE_MASK) == READ_ZERO)
		else $error("reserved control bits set");

	// byte and halfword writes are refused rather than merged into the word
	a_narrow_dropped: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ2]
		(dataPhase.valid && dataPhase.write && !dataPhase.wordSize) |=> $stable(ctrl))
		else $error("narrow write reached the control register");

	a_unmapped_write: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ2]
		(dataPhase.valid && dataPhase.write && !isControlReg(dataPhase.offset))
			|=> $stable(ctrl))
		else $error("write to another offset reached the control register");

	a_mac_held: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ7]
		(ethernetMacReset && !ctrlWrite) |=> ethernetMacReset)
		else $error("mac reset released without a write");

	a_phy_release: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ7]
		(ctrlWrite && !hwdata[PHY_BIT]) |=> !ethernetPhyReset)
		else $error("phy reset not released on clear");

	a_phy_gate_off: assert property (@(posedge mclk) disable iff (!rstSync_n) // [RQ1]
		(ctrlWrite && !capMask[PHY_BIT]) |=> !ethernetPhyReset)
		else $error("phy reset set although the unit is absent");

endmodule

`default_nettype wire

// ---- test/test_soft_reset_bank_two.sv ----
// self-checking bench for the second soft reset control bank
`default_nettype none

module test_soft_reset_bank_two
	import soft_reset_bank_two_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// stimulus and observation
	logic mclk, arstN, hsel, hwrite, hreadyout, hresp, phyRst, macRst;
	logic [1:0] htrans;
	logic [2:0] hsize, sizeSel;
	logic [DATA_W-1:0] haddr, hwdata, hrdata, capMask, rd;
	logic [7:0] portRst;
	logic [9:0] outs;
	int failCount, checkCount, cycles;

	assign outs = {phyRst, macRst, portRst};

	soft_reset_bank_two soft_reset_bank_two_inst (.mclk(mclk), .arst_n(arstN), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.capabilityMaskFour(capMask), .ethernetPhyReset(phyRst), .ethernetMacReset(macRst),
		.ioPortHReset(portRst[7]), .ioPortGReset(portRst[6]), .ioPortFReset(portRst[5]),
		.ioPortEReset(portRst[4]), .ioPortDReset(portRst[3]), .ioPortCReset(portRst[2]),
		.ioPortBReset(portRst[1]), .ioPortAReset(portRst[0]));

	always #5 mclk = ~mclk;

	// ==========================================================
	// shared tasks
	task automatic results();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// entered just after a rising edge; returns at the edge ending the data phase
	task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
		logic rdy;
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= sizeSel;
		do begin
			@(negedge mclk);
			rdy = hreadyout;
			@(posedge mclk);
		end while (rdy !== 1'b1);
		htrans <= HTRANS_IDLE;
		hwdata <= wd;
		do begin
			@(negedge mclk);
			rdy = hreadyout;
			rd = hrdata;
			@(posedge mclk);
		end while (rdy !== 1'b1);
	endtask

	task automatic checkOuts(input logic [9:0] exp);
		@(negedge mclk);
		check({22'h0, outs}, {22'h0, exp});
		@(posedge mclk);
	endtask

	task automatic startUp();
		arstN <= 1'b0;
		repeat (4) @(posedge mclk);
		arstN <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask

	// ==========================================================
	// scenarios
	task automatic scnResetValue();
		xfer(1'b0, 32'h0000_0048, 32'h0);
		check(rd, 32'h0000_0000);
		checkOuts(10'h000);
	endtask

	task automatic scnFullWrite();
		capMask <= 32'hFFFF_FFFF;
		xfer(1'b1, 32'h0000_0048, 32'hFFFF_FFFF);
		xfer(1'b0, 32'h0000_0048, 32'h0);
		check(rd, 32'h5000_00FF);
		checkOuts(10'h3FF);
	endtask

	task automatic scnWalk();
		int pos;
		for (int i = 0; i < 10; i++) begin
			pos = (i < 8) ? i : ((i == 8) ? 28 : 30);
			xfer(1'b1, 32'h0000_0048, 32'h1 << pos);
			checkOuts(10'h1 << i);
		end
	endtask

	task automatic scnGate();
		capMask <= 32'h1000_0055;
		xfer(1'b1, 32'h0000_0048, 32'hFFFF_FFFF);
		xfer(1'b0, 32'h0000_0048, 32'h0);
		check(rd, 32'h1000_0055);
		checkOuts({1'b0, 1'b1, 8'h55});
		xfer(1'b1, 32'h0000_0048, 32'h0);
		checkOuts(10'h000);
	endtask

	task automatic scnUnmapped();
		xfer(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
		xfer(1'b0, 32'h0000_0100, 32'h0);
		check(rd, 32'h0000_0000);
		xfer(1'b0, 32'h0000_0048, 32'h0);
		check(rd, 32'h0000_0000);
	endtask

	task automatic scnCapability();
		capMask <= 32'h5000_0003;
		xfer(1'b1, 32'h0000_001C, 32'h0000_0000);
		xfer(1'b0, 32'h0000_001C, 32'h0);
		check(rd, 32'h5000_0003);
		sizeSel = 3'h0;
		xfer(1'b1, 32'h0000_0048, 32'hFFFF_FFFF);
		xfer(1'b0, 32'h0000_0048, 32'h0);
		sizeSel = HSIZE_WORD;
		check(rd, 32'h0000_0000);
		checkOuts(10'h000);
		@(negedge mclk);
		check({30'h0, hreadyout, hresp}, {30'h0, 1'b1, HRESP_OKAY});
		@(posedge mclk);
	endtask

	task automatic scnMidReset();
		capMask <= 32'hFFFF_FFFF;
		xfer(1'b1, 32'h0000_0048, 32'hFFFF_FFFF);
		arstN <= 1'b0;
		@(negedge mclk);
		check({22'h0, outs}, 32'h0);
		@(posedge mclk);
		startUp();
		scnResetValue();
	endtask

	// ==========================================================
	// main sequence and hang limit
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failCount++;
			results();
		end
	end

	initial begin
		mclk = 1'b0;
		arstN = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = HTRANS_IDLE;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		sizeSel = HSIZE_WORD;
		hwdata = '0;
		capMask = '0;
		startUp();
		scnResetValue();
		scnFullWrite();
		scnWalk();
		scnGate();
		scnUnmapped();
		scnCapability();
		scnMidReset();
		results();
	end
endmodule

`default_nettype wire
